// *** bss_pkg.sv ***
package bss_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_MHZ        = 250;
    localparam int OC_FILT_NS     = 10000;
    localparam int OV_FILT_NS     = 2000;
    localparam int UV_FILT_NS     = 2000;
    localparam int START_DELAY_NS = 20000;

    localparam int OC_FILT_CYC     = OC_FILT_NS * CLK_MHZ / 1000;
    localparam int OV_FILT_CYC     = OV_FILT_NS * CLK_MHZ / 1000;
    localparam int UV_FILT_CYC     = UV_FILT_NS * CLK_MHZ / 1000;
    localparam int START_DELAY_CYC = START_DELAY_NS * CLK_MHZ / 1000;

    localparam int FILT_W  = 12;
    localparam int DELAY_W = 13;

    // ==========================================================
    // Soft-start current limit, in microamps
    // ==========================================================
    localparam int SS_CURRENT_UA = 20;

    // ==========================================================
    // Power-ok pull-down codes, strongest at the bottom
    // ==========================================================
    localparam logic [1:0] PG_RELEASE = 2'h0;
    localparam logic [1:0] PG_UV_95   = 2'h1;
    localparam logic [1:0] PG_OV_65   = 2'h2;
    localparam logic [1:0] PG_OC_35   = 2'h3;

    typedef enum logic [2:0] {
        BSS_OFF     = 3'b000,
        BSS_DELAY   = 3'b001,
        BSS_RAMP    = 3'b010,
        BSS_RUN     = 3'b011,
        BSS_LATCHED = 3'b100
    } bss_state_e;

endpackage : bss_pkg

// *** bss_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
module bss_filter
    import bss_pkg::*;
#(
    parameter int LIMIT = 500
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic level_i,
    output logic      fire_o
);
    logic [FILT_W-1:0] count;

    // ==========================================================
    // Run-length counter
    // ==========================================================
    // Any drop of the input restarts the count, so only an unbroken excursion fires.
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !level_i) begin
            count  <= '0;
            fire_o <= 1'b0;
        end else if (count != LIMIT[FILT_W-1:0]) begin
            count  <= count + 1'b1;
            fire_o <= 1'b0;
        end else begin
            fire_o <= 1'b1;
        end
    end
endmodule : bss_filter
`default_nettype wire

// *** bss_ovclamp.sv ***
`timescale 1ns/1ns
`default_nettype none
module bss_ovclamp
    import bss_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic armed_i,
    input  wire logic ov_rise_fire_i,
    input  wire logic ov_fall_fire_i,
    output logic      low_on_o
);
    // ==========================================================
    // Discharge control of the low-side gate
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !armed_i) begin
            low_on_o <= 1'b0;
        end else if (ov_rise_fire_i) begin
            low_on_o <= 1'b1;
        end else if (ov_fall_fire_i) begin
            low_on_o <= 1'b0;
        end
    end
endmodule : bss_ovclamp
`default_nettype wire

// *** bss_supervisor.sv ***
// How it works
// - Supply and enable good start soft-start.
// - Soft-start charges with 20 uA limit.
// - Ramp done: flag, release power-ok, allow emulation.
// - Overcurrent needs over 10 us unbroken.
// - Overcurrent latches off, 35 ohm code.
// - Overcurrent, undervoltage clear on enable or supply.
// - Overvoltage needs over 2 us above rise.
// - Overvoltage latches off, 65 ohm code.
// - Overvoltage clears only on supply loss.
// - Overvoltage latched: low gate on each excursion.
// - Low gate off after 2 us below fall.
// - Undervoltage needs over 2 us below threshold.
// - Undervoltage latches off, 95 ohm code.
// - Over-temperature forces gates low, except the overvoltage low gate; no latch.
// - Over-temperature releases on clear, enable, supply.
// - Other detectors stay active during over-temperature.
// - Wait 20 us before reference ramps.
// - No diode emulation before ramp done.
// - Soft-start shows the 95 ohm code.
`timescale 1ns/1ns
`default_nettype none
module bss_supervisor
    import bss_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       NRST_I,
    input  wire logic       SUPPLY_GOOD_I,
    input  wire logic       ENABLE_HIGH_I,
    input  wire logic       SETPOINT_REF_AT_REF_I,
    input  wire logic       OVERCURRENT_SENSE_ABOVE_I,
    input  wire logic       FB_ABOVE_OV_RISE_I,
    input  wire logic       FB_BELOW_OV_FALL_I,
    input  wire logic       FB_BELOW_UV_I,
    input  wire logic       OVER_TEMP_I,
    input  wire logic       PWM_HIGH_REQ_I,
    input  wire logic       PWM_LOW_REQ_I,
    output logic            SETPOINT_REF_CLAMP_O,
    output logic            REF_AMP_ENABLE_O,
    output logic            SS_CURRENT_EN_O,
    output logic            SOFTSTART_DONE_FLAG_O,
    output logic            DIODE_EMULATION_EN_O,
    output logic [1:0]      POWER_OK_CODE_O,
    output logic            POWER_OK_OE_O,
    output logic            HIGH_SIDE_GATE_O,
    output logic            LOW_SIDE_GATE_O,
    output logic            OVERCURRENT_FAULT_O,
    output logic            OVERVOLTAGE_FAULT_O,
    output logic            UNDERVOLTAGE_FAULT_O,
    output logic            OVER_TEMP_STATE_O
);
    bss_state_e           state;
    bss_state_e           next_state;
    logic [DELAY_W-1:0]   delay_count;
    logic                 oc_fire;
    logic                 ov_rise_fire;
    logic                 ov_fall_fire;
    logic                 uv_fire;
    logic                 oc_latch;
    logic                 ov_latch;
    logic                 uv_latch;
    logic                 ot_state;
    logic                 ov_low_on;
    logic                 any_fault;
    logic                 soft_clear;
    logic                 enable_ok;
    logic                 gates_idle;

    // ==========================================================
    // Comparator filters
    // ==========================================================
    bss_filter #(.LIMIT(OC_FILT_CYC)) u_oc_filt (
        .clk_i   (CLK_I),
        .nrst_i  (NRST_I),
        .level_i (OVERCURRENT_SENSE_ABOVE_I),
        .fire_o  (oc_fire)
    );

    bss_filter #(.LIMIT(OV_FILT_CYC)) u_ov_rise_filt (
        .clk_i   (CLK_I),
        .nrst_i  (NRST_I),
        .level_i (FB_ABOVE_OV_RISE_I),
        .fire_o  (ov_rise_fire)
    );

    bss_filter #(.LIMIT(OV_FILT_CYC)) u_ov_fall_filt (
        .clk_i   (CLK_I),
        .nrst_i  (NRST_I),
        .level_i (FB_BELOW_OV_FALL_I),
        .fire_o  (ov_fall_fire)
    );

    bss_filter #(.LIMIT(UV_FILT_CYC)) u_uv_filt (
        .clk_i   (CLK_I),
        .nrst_i  (NRST_I),
        .level_i (FB_BELOW_UV_I),
        .fire_o  (uv_fire)
    );

    bss_ovclamp u_ovclamp (
        .clk_i          (CLK_I),
        .nrst_i         (NRST_I),
        .armed_i        (ov_latch),
        .ov_rise_fire_i (ov_rise_fire),
        .ov_fall_fire_i (ov_fall_fire),
        .low_on_o       (ov_low_on)
    );

    // ==========================================================
    // Clear conditions
    // ==========================================================
    assign enable_ok  = SUPPLY_GOOD_I && ENABLE_HIGH_I;
    assign soft_clear = !enable_ok;
    assign any_fault  = oc_latch || ov_latch || uv_latch;
    assign gates_idle = state == BSS_OFF || state == BSS_DELAY || state == BSS_LATCHED;

    // ==========================================================
    // Fault latches
    // ==========================================================
    // A detection in the same cycle as a clear is dropped, as detection needs the enable high.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || !SUPPLY_GOOD_I) begin
            oc_latch <= 1'b0;
        end else if (oc_fire && ENABLE_HIGH_I) begin
            oc_latch <= 1'b1;
        end else if (soft_clear) begin
            oc_latch <= 1'b0;
        end
    end

    // No enable term here: only a supply loss may release an overvoltage latch.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || !SUPPLY_GOOD_I) begin
            ov_latch <= 1'b0;
        end else if (ov_rise_fire && state != BSS_OFF) begin
            ov_latch <= 1'b1;
        end
    end

    // Undervoltage is meaningless before the ramp settles, so it is armed in run and during over-temperature.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || !SUPPLY_GOOD_I) begin
            uv_latch <= 1'b0;
        end else if (uv_fire && ENABLE_HIGH_I && (state == BSS_RUN || ot_state)) begin
            uv_latch <= 1'b1;
        end else if (soft_clear) begin
            uv_latch <= 1'b0;
        end
    end

    // ==========================================================
    // Over-temperature state
    // ==========================================================
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || soft_clear) begin
            ot_state <= 1'b0;
        end else begin
            ot_state <= OVER_TEMP_I;
        end
    end

    // ==========================================================
    // Start-up sequence
    // ==========================================================
    always_comb begin
        next_state = state;
        unique case (state)
            BSS_OFF: begin
                if (enable_ok && !ov_latch) begin
                    next_state = BSS_DELAY;
                end
            end
            BSS_DELAY: begin
                if (delay_count == START_DELAY_CYC[DELAY_W-1:0]) begin
                    next_state = BSS_RAMP;
                end
            end
            BSS_RAMP: begin
                if (SETPOINT_REF_AT_REF_I) begin
                    next_state = BSS_RUN;
                end
            end
            BSS_RUN: begin
                next_state = BSS_RUN;
            end
            BSS_LATCHED: begin
                next_state = BSS_LATCHED;
            end
            default: begin
                next_state = BSS_OFF;
            end
        endcase
        if (any_fault) begin
            next_state = BSS_LATCHED;
        end
        if (soft_clear && !ov_latch) begin
            next_state = BSS_OFF;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            state <= BSS_OFF;
        end else begin
            state <= next_state;
        end
    end

    // The counter stops at its end value, so a long stay in delay cannot wrap.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || state != BSS_DELAY) begin
            delay_count <= '0;
        end else if (delay_count != START_DELAY_CYC[DELAY_W-1:0]) begin
            delay_count <= delay_count + 1'b1;
        end
    end

    // ==========================================================
    // Registered outputs
    // ==========================================================
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            SETPOINT_REF_CLAMP_O <= 1'b1;
        end else begin
            SETPOINT_REF_CLAMP_O <= (next_state == BSS_OFF);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            REF_AMP_ENABLE_O <= 1'b0;
        end else begin
            REF_AMP_ENABLE_O <= (next_state != BSS_OFF && next_state != BSS_LATCHED);
        end
    end

    // The analog follower sets the 20 uA limit; this enable only gates that source.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            SS_CURRENT_EN_O <= 1'b0;
        end else begin
            SS_CURRENT_EN_O <= (next_state == BSS_RAMP);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            SOFTSTART_DONE_FLAG_O <= 1'b0;
        end else begin
            SOFTSTART_DONE_FLAG_O <= (next_state == BSS_RUN);
        end
    end

    // Emulation waits for the ramp to end, so start-up always runs in continuous conduction.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            DIODE_EMULATION_EN_O <= 1'b0;
        end else begin
            DIODE_EMULATION_EN_O <= (next_state == BSS_RUN) && !ot_state;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            POWER_OK_CODE_O <= PG_UV_95;
            POWER_OK_OE_O   <= 1'b1;
        end else if (oc_latch) begin
            POWER_OK_CODE_O <= PG_OC_35;
            POWER_OK_OE_O   <= 1'b1;
        end else if (ov_latch) begin
            POWER_OK_CODE_O <= PG_OV_65;
            POWER_OK_OE_O   <= 1'b1;
        end else if (uv_latch || state != BSS_RUN) begin
            POWER_OK_CODE_O <= PG_UV_95;
            POWER_OK_OE_O   <= 1'b1;
        end else begin
            POWER_OK_CODE_O <= PG_RELEASE;
            POWER_OK_OE_O   <= 1'b0;
        end
    end

    // ==========================================================
    // Gate drive
    // ==========================================================
    // Latched is idle too: an overvoltage supply-loss clear leaves one cycle in it before off.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            HIGH_SIDE_GATE_O <= 1'b0;
        end else if (any_fault || ot_state || gates_idle) begin
            HIGH_SIDE_GATE_O <= 1'b0;
        end else begin
            HIGH_SIDE_GATE_O <= PWM_HIGH_REQ_I && !PWM_LOW_REQ_I;
        end
    end

    // Both requests at once give neither gate unless an overvoltage latch drives the low gate, so the pair can never shoot through.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            LOW_SIDE_GATE_O <= 1'b0;
        end else if (ov_latch) begin
            LOW_SIDE_GATE_O <= ov_low_on;
        end else if (any_fault || ot_state || gates_idle) begin
            LOW_SIDE_GATE_O <= 1'b0;
        end else begin
            LOW_SIDE_GATE_O <= PWM_LOW_REQ_I && !PWM_HIGH_REQ_I;
        end
    end

    // ==========================================================
    // Fault flag copies
    // ==========================================================
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            OVERCURRENT_FAULT_O <= 1'b0;
        end else begin
            OVERCURRENT_FAULT_O <= oc_latch;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            OVERVOLTAGE_FAULT_O <= 1'b0;
        end else begin
            OVERVOLTAGE_FAULT_O <= ov_latch;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            UNDERVOLTAGE_FAULT_O <= 1'b0;
        end else begin
            UNDERVOLTAGE_FAULT_O <= uv_latch;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            OVER_TEMP_STATE_O <= 1'b0;
        end else begin
            OVER_TEMP_STATE_O <= ot_state;
        end
    end
endmodule : bss_supervisor
`default_nettype wire

// *** bss_supervisor_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Port checker for the soft-start and fault supervisor
module bss_supervisor_chk
    import bss_pkg::*;
(
    input wire logic       CLK_I,
    input wire logic       NRST_I,
    input wire logic       SUPPLY_GOOD_I,
    input wire logic       ENABLE_HIGH_I,
    input wire logic       OVERCURRENT_SENSE_ABOVE_I,
    input wire logic       FB_BELOW_UV_I,
    input wire logic       SETPOINT_REF_CLAMP_O,
    input wire logic       REF_AMP_ENABLE_O,
    input wire logic       SS_CURRENT_EN_O,
    input wire logic       SOFTSTART_DONE_FLAG_O,
    input wire logic [1:0] POWER_OK_CODE_O,
    input wire logic       POWER_OK_OE_O,
    input wire logic       HIGH_SIDE_GATE_O,
    input wire logic       LOW_SIDE_GATE_O,
    input wire logic       OVERCURRENT_FAULT_O,
    input wire logic       OVERVOLTAGE_FAULT_O,
    input wire logic       UNDERVOLTAGE_FAULT_O,
    input wire logic       OVER_TEMP_STATE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    logic [1:0]  lv;
    logic [1:0]  seen;
    logic [12:0] run [2];
    logic [12:0] amp_n;
    logic        ok;
    assign lv = {OVERCURRENT_SENSE_ABOVE_I, FB_BELOW_UV_I};
    assign ok = ENABLE_HIGH_I && SUPPLY_GOOD_I;
    // A long run is remembered until a soft clear, as the latch may land after it ends.
    always_ff @(posedge CLK_I) begin
        for (int i = 0; i < 2; i++) begin
            run[i] <= (lv[i] && NRST_I) ? run[i] + {12'h0, run[i] != 13'h1FFF} : 13'h0;
            if (!NRST_I || !ok)
                seen[i] <= 1'b0;
            else if (run[i] > (i == 1 ? OC_FILT_CYC : UV_FILT_CYC))
                seen[i] <= 1'b1;
        end
        amp_n <= REF_AMP_ENABLE_O ? amp_n + 13'h1 : 13'h0;
    end
    a_start_release: assert property (
        $rose(REF_AMP_ENABLE_O) |-> !SETPOINT_REF_CLAMP_O && $past(ENABLE_HIGH_I))
        else $error("reference amp on without release");
    a_start_wait: assert property ($rose(SS_CURRENT_EN_O) |-> amp_n >= START_DELAY_CYC)
        else $error("ramp began before the start delay");
    a_ramp_code: assert property (
        SS_CURRENT_EN_O |-> POWER_OK_OE_O && POWER_OK_CODE_O == PG_UV_95)
        else $error("ramp without soft-start code");
    a_done_release: assert property (
        $rose(SOFTSTART_DONE_FLAG_O) |=> !POWER_OK_OE_O && POWER_OK_CODE_O == PG_RELEASE)
        else $error("power ok not released after ramp");
    a_oc_filter: assert property ($rose(OVERCURRENT_FAULT_O) |-> seen[1])
        else $error("overcurrent latched too soon");
    a_uv_filter: assert property ($rose(UNDERVOLTAGE_FAULT_O) |-> seen[0])
        else $error("undervoltage latched too soon");
    a_oc_code: assert property (
        OVERCURRENT_FAULT_O && $past(OVERCURRENT_FAULT_O) && ok |-> POWER_OK_CODE_O == PG_OC_35)
        else $error("overcurrent code wrong");
    a_ov_code: assert property (
        OVERVOLTAGE_FAULT_O && $past(OVERVOLTAGE_FAULT_O) && !OVERCURRENT_FAULT_O
        && SUPPLY_GOOD_I |-> POWER_OK_OE_O && POWER_OK_CODE_O == PG_OV_65)
        else $error("overvoltage code wrong");
    a_uv_code: assert property (
        UNDERVOLTAGE_FAULT_O && $past(UNDERVOLTAGE_FAULT_O) && !OVERCURRENT_FAULT_O
        && !OVERVOLTAGE_FAULT_O && ok |-> POWER_OK_OE_O && POWER_OK_CODE_O == PG_UV_95)
        else $error("undervoltage code wrong");
    a_gates_latched: assert property (
        OVERCURRENT_FAULT_O || UNDERVOLTAGE_FAULT_O || OVERVOLTAGE_FAULT_O
        |-> !HIGH_SIDE_GATE_O && (OVERVOLTAGE_FAULT_O || !LOW_SIDE_GATE_O))
        else $error("gate driven while latched off");
    a_thermal_gates: assert property (
        OVER_TEMP_STATE_O && $past(OVER_TEMP_STATE_O) && !OVERVOLTAGE_FAULT_O
        |-> !HIGH_SIDE_GATE_O && !LOW_SIDE_GATE_O)
        else $error("gate driven in thermal pause");
endmodule // bss_supervisor_chk
bind bss_supervisor bss_supervisor_chk u_chk (.*);
`default_nettype wire

// *** bss_plant.sv ***
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Far side: reference node charge and modulator requests
module bss_plant (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic ss_en_i,
    output logic      at_ref_o,
    output logic      hi_o,
    output logic      lo_o
);
    logic [5:0] chg;
    logic [2:0] ph;
    // Charging takes a few dozen cycles so the ramp phase is really observed.
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !ss_en_i)
            chg <= 6'h0;
        else if (chg != 6'h3F)
            chg <= chg + 6'h1;
    end
    always_ff @(posedge clk_i) begin
        ph <= nrst_i ? ph + 3'h1 : 3'h0;
    end
    assign at_ref_o = chg[5];
    assign hi_o     = ph[2];
    assign lo_o     = !ph[2];
endmodule // bss_plant
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Self-checking bench for the soft-start and fault supervisor
module tb_top;
    import bss_pkg::*;
    logic CLK_I = 1'b0, NRST_I = 1'b0, SUPPLY_GOOD_I = 1'b0, ENABLE_HIGH_I = 1'b0;
    logic OVERCURRENT_SENSE_ABOVE_I = 1'b0, FB_ABOVE_OV_RISE_I = 1'b0;
    logic FB_BELOW_OV_FALL_I = 1'b0, FB_BELOW_UV_I = 1'b0, OVER_TEMP_I = 1'b0;
    logic SETPOINT_REF_AT_REF_I, PWM_HIGH_REQ_I, PWM_LOW_REQ_I, SETPOINT_REF_CLAMP_O;
    logic REF_AMP_ENABLE_O, SS_CURRENT_EN_O, SOFTSTART_DONE_FLAG_O, DIODE_EMULATION_EN_O;
    logic POWER_OK_OE_O, HIGH_SIDE_GATE_O, LOW_SIDE_GATE_O, OVERCURRENT_FAULT_O;
    logic OVERVOLTAGE_FAULT_O, UNDERVOLTAGE_FAULT_O, OVER_TEMP_STATE_O;
    logic [1:0] POWER_OK_CODE_O, g;
    int bad_count = 0;
    int n_compared = 0;
    int i;
    bss_supervisor u_dut (.*);
    bss_plant u_plant (.clk_i(CLK_I), .nrst_i(NRST_I), .ss_en_i(SS_CURRENT_EN_O),
        .at_ref_o(SETPOINT_REF_AT_REF_I), .hi_o(PWM_HIGH_REQ_I), .lo_o(PWM_LOW_REQ_I));
    initial begin
        forever #2 CLK_I = ~CLK_I;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask
    task automatic chk(input logic [5:0] got, input logic [5:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t %s got %0h want %0h", $time, m, got, exp);
        end
    endtask
    // Sampling a window rather than one cycle keeps the check free of the PWM phase.
    task automatic gates(output logic [1:0] s);
        s = 2'h0;
        repeat (16) begin
            cyc(1);
            s = s | {HIGH_SIDE_GATE_O, LOW_SIDE_GATE_O};
        end
    endtask
    task automatic start();
        @(posedge CLK_I) {SUPPLY_GOOD_I, ENABLE_HIGH_I} <= 2'h3;
        cyc(100);
        chk({REF_AMP_ENABLE_O, SETPOINT_REF_CLAMP_O}, 6'h2, "amp");
        chk({DIODE_EMULATION_EN_O, POWER_OK_OE_O, POWER_OK_CODE_O}, 6'h5, "delay");
        cyc(START_DELAY_CYC - 150);
        chk(SS_CURRENT_EN_O, 6'h0, "early ramp");
        for (i = 0; i < 200 && SS_CURRENT_EN_O !== 1'b1; i++) cyc(1);
        chk(SS_CURRENT_EN_O, 6'h1, "ramp");
        for (i = 0; i < 200 && SOFTSTART_DONE_FLAG_O !== 1'b1; i++) cyc(1);
        cyc(2);
        chk({SOFTSTART_DONE_FLAG_O, DIODE_EMULATION_EN_O, POWER_OK_OE_O,
            POWER_OK_CODE_O}, 6'h18, "done");
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge CLK_I);
        bad_count++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        give_verdict();
    end
    initial begin
        cyc(16);
        chk({SETPOINT_REF_CLAMP_O, POWER_OK_OE_O, POWER_OK_CODE_O}, 6'hD, "reset");
        @(posedge CLK_I) NRST_I <= 1'b1;
        start();
        @(posedge CLK_I) OVER_TEMP_I <= 1'b1;
        cyc(4);
        gates(g);
        chk({g, POWER_OK_OE_O, UNDERVOLTAGE_FAULT_O}, 6'h0, "thermal");
        @(posedge CLK_I) OVER_TEMP_I <= 1'b0;
        cyc(4);
        gates(g);
        chk(g, 6'h3, "thermal end");
        @(posedge CLK_I) {OVER_TEMP_I, FB_BELOW_UV_I} <= 2'h3;
        cyc(UV_FILT_CYC + 10);
        chk({UNDERVOLTAGE_FAULT_O, POWER_OK_OE_O, POWER_OK_CODE_O}, 6'hD, "uv");
        @(posedge CLK_I) ENABLE_HIGH_I <= 1'b0;
        cyc(5);
        chk({UNDERVOLTAGE_FAULT_O, OVER_TEMP_STATE_O}, 6'h0, "uv clear");
        @(posedge CLK_I) {OVER_TEMP_I, FB_BELOW_UV_I} <= 2'h0;
        $display("test thermal and undervoltage done");
        start();
        @(posedge CLK_I) OVERCURRENT_SENSE_ABOVE_I <= 1'b1;
        repeat (OC_FILT_CYC) @(posedge CLK_I);
        OVERCURRENT_SENSE_ABOVE_I <= 1'b0;
        cyc(10);
        chk(OVERCURRENT_FAULT_O, 6'h0, "oc boundary");
        @(posedge CLK_I) OVERCURRENT_SENSE_ABOVE_I <= 1'b1;
        cyc(100);
        chk(OVERCURRENT_FAULT_O, 6'h0, "oc restart");
        cyc(OC_FILT_CYC - 90);
        gates(g);
        chk({g, OVERCURRENT_FAULT_O, POWER_OK_OE_O, POWER_OK_CODE_O}, 6'hF, "oc");
        @(posedge CLK_I) {ENABLE_HIGH_I, OVERCURRENT_SENSE_ABOVE_I} <= 2'h0;
        cyc(5);
        chk(OVERCURRENT_FAULT_O, 6'h0, "oc clear");
        $display("test overcurrent done");
        start();
        @(posedge CLK_I) FB_ABOVE_OV_RISE_I <= 1'b1;
        cyc(OV_FILT_CYC + 10);
        chk({OVERVOLTAGE_FAULT_O, POWER_OK_OE_O, POWER_OK_CODE_O, HIGH_SIDE_GATE_O,
            LOW_SIDE_GATE_O}, 6'h39, "ov");
        @(posedge CLK_I) {FB_ABOVE_OV_RISE_I, FB_BELOW_OV_FALL_I} <= 2'h1;
        cyc(OV_FILT_CYC + 10);
        chk(LOW_SIDE_GATE_O, 6'h0, "low gate off");
        @(posedge CLK_I) {FB_ABOVE_OV_RISE_I, FB_BELOW_OV_FALL_I} <= 2'h2;
        cyc(OV_FILT_CYC + 10);
        chk(LOW_SIDE_GATE_O, 6'h1, "low gate again");
        @(posedge CLK_I) {FB_ABOVE_OV_RISE_I, ENABLE_HIGH_I} <= 2'h0;
        cyc(10);
        chk(OVERVOLTAGE_FAULT_O, 6'h1, "ov hold");
        @(posedge CLK_I) SUPPLY_GOOD_I <= 1'b0;
        cyc(5);
        chk(OVERVOLTAGE_FAULT_O, 6'h0, "ov clear");
        $display("test overvoltage done");
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
